// ### core/mrd_pkg.sv
// constants and types for the move and return instruction decoder
// assumes a single core clock and instruction words from same-clock fetch logic
// How it works
// RL1 - store accumulator into data register, one cycle
// RL2 - copy accumulator into special register, one cycle
// RL3 - plain return pops stack, two cycles
// RL4 - interrupt return pops stack, sets global enable
// RL5 - literal return loads accumulator, pops stack
// RL6 - literal return takes pc from stack top
// RL7 - no-operation changes nothing except pc increment
package mrd_pkg;
	localparam int INSTR_W = 14;
	localparam int DATA_W  = 8;
	localparam int FADDR_W = 7;
	localparam int RADDR_W = 6;
	// program counter width is not fixed by the instruction set
	localparam int PC_W    = 10;

	localparam logic [INSTR_W-1:0] OP_NOP      = 14'h0000;
	localparam logic [INSTR_W-1:0] OP_SUB_RETURN = 14'h0040;
	localparam logic [INSTR_W-1:0] OP_INT_RETURN = 14'h0060;
	localparam logic [INSTR_W-1:0] MASK_FILE   = 14'h3f80;
	localparam logic [INSTR_W-1:0] MATCH_FILE  = 14'h0080;
	localparam logic [INSTR_W-1:0] MASK_SPEC   = 14'h3fc0;
	localparam logic [INSTR_W-1:0] MATCH_SPEC  = 14'h0000;
	localparam logic [INSTR_W-1:0] MASK_LIT_RETURN  = 14'h3f00;
	localparam logic [INSTR_W-1:0] MATCH_LIT_RETURN = 14'h1800;

	localparam int RETURN_CYCLES = 2;

	localparam logic [DATA_W-1:0]  DATA_RST = 8'h00;
	localparam logic [PC_W-1:0]    PC_RST   = 10'h000;
	localparam logic [FADDR_W-1:0] FADDR_RST = 7'h00;
	localparam logic [RADDR_W-1:0] RADDR_RST = 6'h00;

	typedef enum logic {
		ST_RUN,
		ST_FLUSH
	} mrd_state_t;
endpackage

// ### core/mrd_dec_if.sv
// decode flags passed from the opcode matcher to the executing core
// assumes both ends sit on the same clock
`timescale 1ns/1ps
interface mrd_dec_if;
	import mrd_pkg::*;
	logic [INSTR_W-1:0] instr;
	logic               is_nop;
	logic               is_file;
	logic               is_spec;
	logic               is_sub_return;
	logic               is_int_return;
	logic               is_lit_return;

	modport dec
	(
		input  instr,
		output is_nop,
		output is_file,
		output is_spec,
		output is_sub_return,
		output is_int_return,
		output is_lit_return
	);
	modport core
	(
		output instr,
		input  is_nop,
		input  is_file,
		input  is_spec,
		input  is_sub_return,
		input  is_int_return,
		input  is_lit_return
	);
endinterface

// ### core/mrd_decoder.sv
// pure combinational opcode matcher for the move and return group
// assumes the instruction word is stable for the cycle it is presented
`timescale 1ns/1ps
module mrd_decoder
	import mrd_pkg::*;
(
	mrd_dec_if.dec dif
);
	// zero word is the no-operation, so it wins over special store r=0
	assign dif.is_nop   = (dif.instr == OP_NOP);
	assign dif.is_file  = ((dif.instr & MASK_FILE) == MATCH_FILE);
	assign dif.is_spec  = ((dif.instr & MASK_SPEC) == MATCH_SPEC) && !dif.is_nop;
	assign dif.is_sub_return = (dif.instr == OP_SUB_RETURN);
	assign dif.is_int_return = (dif.instr == OP_INT_RETURN);
	assign dif.is_lit_return = ((dif.instr & MASK_LIT_RETURN) == MATCH_LIT_RETURN);
endmodule

// ### core/mrd_core.sv
// executes store, no-operation and the three return instructions
// assumes fetch, register file, stack and interrupt logic sit outside on mclk_i
`timescale 1ns/1ps
module mrd_core
	import mrd_pkg::*;
(
	input  wire logic               mclk_i,
	input  wire logic               rstn_i,
	input  wire logic               instr_valid_i,
	input  wire logic [INSTR_W-1:0] instr_i,
	input  wire logic [DATA_W-1:0]  acc_i,
	input  wire logic [PC_W-1:0]    stack_top_i,
	output logic                    ready_o,
	output logic                    busy_o,
	output logic                    pc_inc_o,
	output logic                    file_we_o,
	output logic [FADDR_W-1:0]      file_addr_o,
	output logic [DATA_W-1:0]       file_wdata_o,
	output logic                    spec_we_o,
	output logic [RADDR_W-1:0]      spec_addr_o,
	output logic [DATA_W-1:0]       spec_wdata_o,
	output logic                    acc_we_o,
	output logic [DATA_W-1:0]       acc_wdata_o,
	output logic                    stack_pop_o,
	output logic                    pc_load_o,
	output logic [PC_W-1:0]         pc_value_o,
	output logic                    global_interrupt_enable_set_o
);
	mrd_dec_if  dif ();
	mrd_state_t state_q;
	mrd_state_t state_d;

	mrd_decoder u_dec
	(
		.dif (dif)
	);

	assign dif.instr = instr_i;

	// words offered during the flush slot are ignored, ready_o tells fetch
	wire take      = instr_valid_i && (state_q == ST_RUN);
	wire return_any  = dif.is_sub_return || dif.is_int_return || dif.is_lit_return;
	wire take_return = take && return_any;
	// RL1 data register store
	wire file_we_d   = take && dif.is_file;
	// RL2 special register store
	wire spec_we_d   = take && dif.is_spec;
	// RL5 literal into accumulator
	wire acc_we_d    = take && dif.is_lit_return;
	// RL4 interrupts re-enabled
	wire int_en_d    = take && dif.is_int_return;
	// RL7 only the increment, no writes
	wire pc_inc_d    = take && !return_any;
	// RL3 handshake follows next state
	wire ready_d     = (state_d == ST_RUN);
	wire busy_d      = (state_d == ST_FLUSH);

	// RL3 second cycle is a dead slot
	always_comb
	begin
		state_d = state_q;
		case (state_q)
			ST_RUN:   if (take_return) state_d = ST_FLUSH;
			ST_FLUSH: state_d = ST_RUN;
			default:  state_d = ST_RUN;
		endcase
	end

	// RL3 state and handshake levels
	always_ff @(posedge mclk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			state_q <= ST_RUN;
			ready_o <= 1'b1;
			busy_o  <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			ready_o <= ready_d;
			busy_o  <= busy_d;
		end
	end

	// RL3 pop and reload together
	always_ff @(posedge mclk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			pc_inc_o                      <= 1'b0;
			file_we_o                     <= 1'b0;
			spec_we_o                     <= 1'b0;
			acc_we_o                      <= 1'b0;
			global_interrupt_enable_set_o <= 1'b0;
			stack_pop_o                   <= 1'b0;
			pc_load_o                     <= 1'b0;
		end
		else
		begin
			pc_inc_o                      <= pc_inc_d;
			file_we_o                     <= file_we_d;
			spec_we_o                     <= spec_we_d;
			acc_we_o                      <= acc_we_d;
			global_interrupt_enable_set_o <= int_en_d;
			stack_pop_o                   <= take_return;
			pc_load_o                     <= take_return;
		end
	end

	// RL1 held until next store
	always_ff @(posedge mclk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			file_addr_o  <= FADDR_RST;
			file_wdata_o <= DATA_RST;
		end
		else if (file_we_d)
		begin
			file_addr_o  <= instr_i[FADDR_W-1:0];
			file_wdata_o <= acc_i;
		end
	end

	// RL2 held until next store
	always_ff @(posedge mclk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			spec_addr_o  <= RADDR_RST;
			spec_wdata_o <= DATA_RST;
		end
		else if (spec_we_d)
		begin
			spec_addr_o  <= instr_i[RADDR_W-1:0];
			spec_wdata_o <= acc_i;
		end
	end

	// RL5 literal kept after the load
	always_ff @(posedge mclk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			acc_wdata_o <= DATA_RST;
		end
		else if (acc_we_d)
		begin
			acc_wdata_o <= instr_i[DATA_W-1:0];
		end
	end

	// RL6 return address from stack top
	always_ff @(posedge mclk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			pc_value_o <= PC_RST;
		end
		else if (take_return)
		begin
			pc_value_o <= stack_top_i;
		end
	end

	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (!rstn_i);

	sequence s_return_issue;
		pc_load_o && stack_pop_o && busy_o && !ready_o;
	endsequence

	sequence s_flush_done;
		!busy_o && ready_o && !pc_load_o && !pc_inc_o && !file_we_o && !spec_we_o && !acc_we_o;
	endsequence

	// no register write and no increment in the issue slot
	sequence s_no_side_effect;
		!file_we_o && !spec_we_o && !pc_inc_o;
	endsequence

	AST_FILE_STORE: assert property (take && dif.is_file |=> file_we_o && !pc_load_o // RL1
		&& file_addr_o == $past(instr_i[FADDR_W-1:0]) && file_wdata_o == $past(acc_i) && ready_o)
		else $error("data register store wrong");

	AST_SPEC_STORE: assert property (take && dif.is_spec |=> spec_we_o && !file_we_o // RL2
		&& spec_addr_o == $past(instr_i[RADDR_W-1:0]) && spec_wdata_o == $past(acc_i) && pc_inc_o)
		else $error("special register store wrong");

	AST_SUB_RETURN_TWO: assert property (take && dif.is_sub_return |=> s_return_issue ##1 s_flush_done) // RL3
		else $error("plain return not two cycles");

	AST_SUB_RETURN_QUIET: assert property (take && dif.is_sub_return |=> s_no_side_effect // RL3
		and (!acc_we_o && !global_interrupt_enable_set_o))
		else $error("plain return touched other state");

	AST_INT_RETURN_ENABLE: assert property (take && dif.is_int_return |=> (s_return_issue // RL4
		and global_interrupt_enable_set_o) ##1 !global_interrupt_enable_set_o)
		else $error("interrupt return did not set enable");

	AST_LIT_RETURN_ACC: assert property (take && dif.is_lit_return |=> (s_return_issue // RL5
		and (acc_we_o && acc_wdata_o == $past(instr_i[DATA_W-1:0]))) ##1 s_flush_done)
		else $error("literal return wrong");

	AST_LIT_RETURN_PC: assert property (take && dif.is_lit_return |=> pc_value_o == $past(stack_top_i)) // RL6
		else $error("return pc not from stack top");

	AST_ANY_RETURN_PC: assert property (take_return |=> pc_load_o && pc_value_o == $past(stack_top_i)) // RL3
		else $error("return did not load stack top");

	AST_NOP_QUIET: assert property (take && dif.is_nop |=> pc_inc_o && !file_we_o && !spec_we_o // RL7
		&& !acc_we_o && !pc_load_o && !global_interrupt_enable_set_o)
		else $error("no-operation changed state");

	AST_ONE_CYCLE: assert property (take && !return_any |=> ready_o && !busy_o) // RL1
		else $error("single cycle instruction stalled");

	// a word offered in the dead slot must leave no trace
	AST_FLUSH_REFUSE: assert property (busy_o |=> s_flush_done) // RL3
		else $error("word taken during flush slot");

	AST_POP_PULSE: assert property (stack_pop_o |=> !stack_pop_o && !pc_load_o // RL3
		&& !global_interrupt_enable_set_o && !acc_we_o)
		else $error("pop strobe longer than one cycle");

	// consumers may sample address and data late, so they must hold
	AST_FILE_HOLD: assert property (!file_we_o |-> $stable(file_addr_o) && $stable(file_wdata_o)) // RL1
		else $error("data register outputs moved without store");

	AST_SPEC_HOLD: assert property (!spec_we_o |-> $stable(spec_addr_o) && $stable(spec_wdata_o)) // RL2
		else $error("special register outputs moved without store");

	AST_ACC_HOLD: assert property (!acc_we_o |-> $stable(acc_wdata_o)) // RL5
		else $error("accumulator data moved without load");

	AST_PC_HOLD: assert property (!pc_load_o |-> $stable(pc_value_o)) // RL6
		else $error("pc value moved without load");
endmodule

// ### bench/mrd_core_bench.sv
// self-checking bench for the move and return executor
// assumes mrd_core alone; fetch, stack and register file are played by this bench
`timescale 1ns/1ps
module mrd_core_bench
	import mrd_pkg::*;
;
	logic               mclk_i        = 1'b0;
	logic               rstn_i        = 1'b0;
	logic               instr_valid_i = 1'b0;
	logic [INSTR_W-1:0] instr_i       = 14'h0000;
	logic [DATA_W-1:0]  acc_i         = 8'h00;
	logic [PC_W-1:0]    stack_top_i   = 10'h000;
	logic               ready_o, busy_o, pc_inc_o, file_we_o, spec_we_o, acc_we_o;
	logic               stack_pop_o, pc_load_o, global_interrupt_enable_set_o;
	logic [FADDR_W-1:0] file_addr_o;
	logic [RADDR_W-1:0] spec_addr_o;
	logic [DATA_W-1:0]  file_wdata_o, spec_wdata_o, acc_wdata_o;
	logic [PC_W-1:0]    pc_value_o;
	int                 n_errors   = 0;
	int                 num_checks = 0;
	int                 cyc        = 0;
	// dead slot after returns shows up as refused words
	logic [13:0] corner [15] = '{14'h0000, 14'h00ff, 14'h0080, 14'h003f, 14'h0001, 14'h0040, 14'h0040, 14'h0060,
		14'h0003, 14'h18ff, 14'h0000, 14'h1900, 14'h1800, 14'h0000, 14'h007f};

	always #10 mclk_i = ~mclk_i;

	mrd_core dut (.mclk_i(mclk_i), .rstn_i(rstn_i), .instr_valid_i(instr_valid_i), .instr_i(instr_i),
		.acc_i(acc_i), .stack_top_i(stack_top_i), .ready_o(ready_o), .busy_o(busy_o), .pc_inc_o(pc_inc_o),
		.file_we_o(file_we_o), .file_addr_o(file_addr_o), .file_wdata_o(file_wdata_o), .spec_we_o(spec_we_o),
		.spec_addr_o(spec_addr_o), .spec_wdata_o(spec_wdata_o), .acc_we_o(acc_we_o), .acc_wdata_o(acc_wdata_o),
		.stack_pop_o(stack_pop_o), .pc_load_o(pc_load_o), .pc_value_o(pc_value_o),
		.global_interrupt_enable_set_o(global_interrupt_enable_set_o));

	task chk(input logic [15:0] a, input logic [15:0] e);
		num_checks++;
		if (a !== e)
		begin
			$display("BAD t=%0t got %h exp %h", $time, a, e);
			n_errors++;
		end
	endtask

	// strobes one edge after a word, in the order of the flag compare
	function automatic logic [8:0] exp_flags(input logic tk, input logic [13:0] w);
		logic lr;
		logic rt;
		lr = w[13:8] == 6'h18;
		rt = w == 14'h0040 || w == 14'h0060 || lr;
		return {!(tk && rt), tk && rt, tk && !rt, tk && w[13:7] == 7'h01,
			tk && w[13:6] == 8'h00 && w != 14'h0000, tk && lr, tk && rt, tk && rt,
			tk && w == 14'h0060};
	endfunction

	task complete_run;
		if (n_errors == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// run needs about 1200 cycles
	always @(posedge mclk_i)
	begin
		cyc <= cyc + 1;
		if (cyc == 3000)
		begin
			n_errors++;
			complete_run();
		end
	end

	initial
	begin
		logic [13:0] w;
		logic        tk, rt, fl, sp, lr;
		logic [8:0]  e_p;
		logic [6:0]  e_fa;
		logic [5:0]  e_sa;
		logic [7:0]  e_fd, e_sd, e_ad;
		logic [9:0]  e_pv;
		logic        m_busy;
		void'($urandom(32'h4575));
		{m_busy, e_fa, e_sa, e_fd, e_sd, e_ad, e_pv} = '0;
		repeat (6) @(posedge mclk_i);
		rstn_i <= 1'b1;
		for (int i = 0; i < 1200; i++)
		begin
			@(posedge mclk_i);
			w = instr_i;
			tk = instr_valid_i && !m_busy;
			lr = w[13:8] == 6'h18;
			rt = w == 14'h0040 || w == 14'h0060 || lr;
			fl = tk && w[13:7] == 7'h01;
			sp = tk && w[13:6] == 8'h00 && w != 14'h0000;
			if (fl) {e_fa, e_fd} = {w[6:0], acc_i};
			if (sp) {e_sa, e_sd} = {w[5:0], acc_i};
			if (tk && rt) e_pv = stack_top_i;
			if (tk && lr) e_ad = w[7:0];
			e_p = exp_flags(tk, w);
			m_busy = tk && rt;
			if (i < 15)
				w = corner[i];
			else
				case ($urandom % 7)
					0: w = 14'h0000;
					1: w = 14'h0080 | 14'($urandom % 128);
					2: w = 14'($urandom % 63 + 1);
					3: w = 14'h0040;
					4: w = 14'h0060;
					5: w = 14'h1800 | 14'($urandom % 256);
					default: w = 14'($urandom);
				endcase
			instr_valid_i <= i < 15 || $urandom % 4 != 0;
			instr_i <= w;
			acc_i <= 8'($urandom);
			stack_top_i <= 10'($urandom);
			#1;
			chk({7'h00, ready_o, busy_o, pc_inc_o, file_we_o, spec_we_o, acc_we_o, stack_pop_o, pc_load_o,
				global_interrupt_enable_set_o}, {7'h00, e_p});
			chk({1'b0, file_addr_o, file_wdata_o}, {1'b0, e_fa, e_fd});
			chk({2'b00, spec_addr_o, spec_wdata_o}, {2'b00, e_sa, e_sd});
			chk({6'h00, pc_value_o}, {6'h00, e_pv});
			chk({8'h00, acc_wdata_o}, {8'h00, e_ad});
		end
		complete_run();
	end
endmodule
